// *** hw/brtr_core.sv ***
`default_nettype none

module brtr_core #(
	parameter int TICK_CYCLES = brtr_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// Processor bus
	input  wire logic       bus_sel_i,
	input  wire logic       wr_en_i,
	input  wire logic       rd_en_i,
	input  wire logic [7:0] wdata_i,
	output logic [7:0]      rdata_o
);

	localparam int NCNT  = 7;
	localparam int DIV_W = brtr_pkg::DIV_W;

	brtr_pkg::brtr_state_t s_reg;
	brtr_pkg::brtr_state_t s_next;

	logic             tick;
	logic             wr_idx;
	logic             wr_dat;
	logic             chk_ok;
	logic             len_ok;
	logic             rd_hit;
	logic [7:0]       rd_val;
	logic [7:0]       chk_val;
	logic [7:0]       chk_lo;
	logic [7:0]       chk_hi;
	logic [7:0]       e_date;
	logic [7:0]       e_mon;
	logic [7:0]       e_year;
	logic [7:0]       e_cent;
	logic [7:0]       cnt_v  [NCNT];
	logic [7:0]       cnt_lo [NCNT];
	logic [7:0]       cnt_hi [NCNT];
	logic [7:0]       cnt_nx [NCNT];
	logic [NCNT-1:0]  wrap;
	logic [7:0]       wday_nx;
	logic             al_hit;

	// ==========================================================
	// Month length with leap years; 1900 is common, 2000 is leap.
	function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y,
		input logic [7:0] c);
		logic leap;
		logic [7:0] len;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		if (y == brtr_pkg::BCD_ZERO) begin
			leap = (c == brtr_pkg::MAX_CENT);
		end
		case (m)
			brtr_pkg::MON_FEB: len = leap ? brtr_pkg::LEN_29 : brtr_pkg::LEN_28;
			brtr_pkg::MON_APR,
			brtr_pkg::MON_JUN,
			brtr_pkg::MON_SEP,
			brtr_pkg::MON_NOV: len = brtr_pkg::LEN_30;
			default: len = brtr_pkg::MAX_DATE;
		endcase
		return len;
	endfunction

	// ==========================================================
	// Bus decode: offset zero is the index, offset one the data.
	assign wr_idx = wr_en_i && !bus_sel_i;
	assign wr_dat = wr_en_i && bus_sel_i;
	assign tick   = (s_reg.div == DIV_W'(TICK_CYCLES - 1));
	assign rdata_o = s_reg.rdata;

	// ==========================================================
	// Counter chain: sec, min, hour, date, month, year, century.
	always_comb begin
		cnt_v[0]  = s_reg.sec;
		cnt_v[1]  = s_reg.min;
		cnt_v[2]  = s_reg.hour;
		cnt_v[3]  = s_reg.date;
		cnt_v[4]  = s_reg.mon;
		cnt_v[5]  = s_reg.year;
		cnt_v[6]  = s_reg.cent;
		cnt_lo[0] = brtr_pkg::BCD_ZERO;
		cnt_lo[1] = brtr_pkg::BCD_ZERO;
		cnt_lo[2] = brtr_pkg::BCD_ZERO;
		cnt_lo[3] = brtr_pkg::BCD_ONE;
		cnt_lo[4] = brtr_pkg::BCD_ONE;
		cnt_lo[5] = brtr_pkg::BCD_ZERO;
		cnt_lo[6] = brtr_pkg::MIN_CENT;
		cnt_hi[0] = brtr_pkg::MAX_MS;
		cnt_hi[1] = brtr_pkg::MAX_MS;
		cnt_hi[2] = brtr_pkg::MAX_HOUR;
		cnt_hi[3] = month_len(s_reg.mon, s_reg.year, s_reg.cent);
		cnt_hi[4] = brtr_pkg::MAX_MON;
		cnt_hi[5] = brtr_pkg::MAX_YEAR;
		cnt_hi[6] = brtr_pkg::MAX_CENT;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCNT; gi++) begin : g_step
			brtr_bcd_step u_step (
				.val_i  (cnt_v[gi]),
				.lo_i   (cnt_lo[gi]),
				.hi_i   (cnt_hi[gi]),
				.nxt_o  (cnt_nx[gi]),
				.wrap_o (wrap[gi])
			);
		end
	endgenerate

	// Weekday wraps 7 to 1 and never touches the date.
	assign wday_nx = (s_reg.wday >= brtr_pkg::MAX_WDAY) ? brtr_pkg::BCD_ONE
		: s_reg.wday + brtr_pkg::BCD_ONE;

	// ==========================================================
	// Entry check limits, chosen by the current index.
	always_comb begin
		chk_val = wdata_i;
		chk_lo  = brtr_pkg::BCD_ZERO;
		chk_hi  = brtr_pkg::MAX_YEAR;
		case (s_reg.idx)
			brtr_pkg::OFF_SEC,
			brtr_pkg::OFF_MIN: chk_hi = brtr_pkg::MAX_MS;
			brtr_pkg::OFF_HOUR: chk_hi = brtr_pkg::MAX_HOUR;
			brtr_pkg::OFF_WDAY: begin
				chk_lo = brtr_pkg::BCD_ONE;
				chk_hi = brtr_pkg::MAX_WDAY;
			end
			brtr_pkg::OFF_DATE: begin
				chk_lo = brtr_pkg::BCD_ONE;
				chk_hi = brtr_pkg::MAX_DATE;
			end
			brtr_pkg::OFF_MON: begin
				chk_lo = brtr_pkg::BCD_ONE;
				chk_hi = brtr_pkg::MAX_MON;
			end
			brtr_pkg::OFF_CENT: begin
				chk_lo = brtr_pkg::MIN_CENT;
				chk_hi = brtr_pkg::MAX_CENT;
			end
			brtr_pkg::OFF_ASEC,
			brtr_pkg::OFF_AMIN: begin
				chk_val = {1'b0, wdata_i[6:0]};
				chk_hi  = brtr_pkg::MAX_MS;
			end
			brtr_pkg::OFF_AHOUR: begin
				chk_val = {1'b0, wdata_i[6:0]};
				chk_hi  = brtr_pkg::MAX_HOUR;
			end
			brtr_pkg::OFF_ADATE: begin
				chk_val = {1'b0, wdata_i[6:0]};
				chk_lo  = brtr_pkg::BCD_ONE;
				chk_hi  = brtr_pkg::MAX_DATE;
			end
			brtr_pkg::OFF_AMON: begin
				chk_val = {1'b0, wdata_i[6:0]};
				chk_lo  = brtr_pkg::BCD_ONE;
				chk_hi  = brtr_pkg::MAX_MON;
			end
			default: chk_hi = brtr_pkg::MAX_YEAR;
		endcase
	end

	brtr_bcd_check u_check (
		.val_i (chk_val),
		.lo_i  (chk_lo),
		.hi_i  (chk_hi),
		.ok_o  (chk_ok)
	);

	// The date must fit the month as it would stand after the write.
	always_comb begin
		e_date = (s_reg.idx == brtr_pkg::OFF_DATE) ? wdata_i : s_reg.date;
		e_mon  = (s_reg.idx == brtr_pkg::OFF_MON) ? wdata_i : s_reg.mon;
		e_year = (s_reg.idx == brtr_pkg::OFF_YEAR) ? wdata_i : s_reg.year;
		e_cent = (s_reg.idx == brtr_pkg::OFF_CENT) ? wdata_i : s_reg.cent;
		len_ok = (e_date <= month_len(e_mon, e_year, e_cent));
	end

	// ==========================================================
	// Read mux; the block's own state shows through status and validity.
	always_comb begin
		rd_hit = 1'b1;
		case (s_reg.idx)
			brtr_pkg::OFF_CR:    rd_val = {6'h00, s_reg.hold};
			brtr_pkg::OFF_SEC:   rd_val = s_reg.sec;
			brtr_pkg::OFF_MIN:   rd_val = s_reg.min;
			brtr_pkg::OFF_HOUR:  rd_val = s_reg.hour;
			brtr_pkg::OFF_WDAY:  rd_val = s_reg.wday;
			brtr_pkg::OFF_DATE:  rd_val = s_reg.date;
			brtr_pkg::OFF_MON:   rd_val = s_reg.mon;
			brtr_pkg::OFF_YEAR:  rd_val = s_reg.year;
			brtr_pkg::OFF_CENT:  rd_val = s_reg.cent;
			brtr_pkg::OFF_ASEC:  rd_val = s_reg.asec;
			brtr_pkg::OFF_AMIN:  rd_val = s_reg.amin;
			brtr_pkg::OFF_AHOUR: rd_val = s_reg.ahour;
			brtr_pkg::OFF_AMON:  rd_val = s_reg.amon;
			brtr_pkg::OFF_ADATE: rd_val = s_reg.adate;
			brtr_pkg::OFF_SR:    rd_val = {5'h00, s_reg.flags};
			brtr_pkg::OFF_INTCR: rd_val = s_reg.int_cr;
			brtr_pkg::OFF_INTSL: rd_val = s_reg.int_sel;
			brtr_pkg::OFF_TVAL:  rd_val = {6'h00, s_reg.tval};
			brtr_pkg::OFF_AVAL:  rd_val = {7'h00, s_reg.aval};
			default: begin
				rd_hit = 1'b0;
				rd_val = 8'h00;
			end
		endcase
	end

	// An alarm needs at least one enabled field, and every enabled field equal.
	assign al_hit = (s_reg.asec[7] || s_reg.amin[7] || s_reg.ahour[7]
			|| s_reg.adate[7] || s_reg.amon[7])
		&& (!s_reg.asec[7] || s_reg.asec[6:0] == s_reg.sec[6:0])
		&& (!s_reg.amin[7] || s_reg.amin[6:0] == s_reg.min[6:0])
		&& (!s_reg.ahour[7] || s_reg.ahour[6:0] == s_reg.hour[6:0])
		&& (!s_reg.adate[7] || s_reg.adate[6:0] == s_reg.date[6:0])
		&& (!s_reg.amon[7] || s_reg.amon[6:0] == s_reg.mon[6:0]);

	// ==========================================================
	// Next state. Writes and clears come first so that hardware sets win.
	always_comb begin
		s_next        = s_reg;
		s_next.div    = tick ? '0 : s_reg.div + 1'b1;
		s_next.hold_d = |s_reg.hold;
		if (wr_idx) begin
			s_next.idx = wdata_i;
		end
		if (rd_en_i) begin
			s_next.rdata = bus_sel_i ? rd_val : s_reg.idx;
		end
		if (wr_dat) begin
			case (s_reg.idx)
				brtr_pkg::OFF_CR: s_next.hold = wdata_i[1:0];
				brtr_pkg::OFF_SEC,
				brtr_pkg::OFF_MIN,
				brtr_pkg::OFF_HOUR: begin
					if (s_reg.hold[brtr_pkg::HOLD_TIME]) begin
						s_next.tval[brtr_pkg::VAL_TIME] = !chk_ok;
						if (chk_ok && s_reg.idx == brtr_pkg::OFF_SEC) s_next.sec = wdata_i;
						if (chk_ok && s_reg.idx == brtr_pkg::OFF_MIN) s_next.min = wdata_i;
						if (chk_ok && s_reg.idx == brtr_pkg::OFF_HOUR) s_next.hour = wdata_i;
					end
				end
				brtr_pkg::OFF_WDAY,
				brtr_pkg::OFF_DATE,
				brtr_pkg::OFF_MON,
				brtr_pkg::OFF_YEAR,
				brtr_pkg::OFF_CENT: begin
					if (s_reg.hold[brtr_pkg::HOLD_CAL]) begin
						s_next.tval[brtr_pkg::VAL_CAL] = !(chk_ok && len_ok);
						if (chk_ok && len_ok) begin
							case (s_reg.idx)
								brtr_pkg::OFF_WDAY: s_next.wday = wdata_i;
								brtr_pkg::OFF_DATE: s_next.date = wdata_i;
								brtr_pkg::OFF_MON:  s_next.mon  = wdata_i;
								brtr_pkg::OFF_YEAR: s_next.year = wdata_i;
								default:            s_next.cent = wdata_i;
							endcase
						end
					end
				end
				brtr_pkg::OFF_ASEC,
				brtr_pkg::OFF_AMIN,
				brtr_pkg::OFF_AHOUR,
				brtr_pkg::OFF_AMON,
				brtr_pkg::OFF_ADATE: begin
					s_next.aval = !chk_ok;
					if (chk_ok) begin
						case (s_reg.idx)
							brtr_pkg::OFF_ASEC:  s_next.asec  = wdata_i;
							brtr_pkg::OFF_AMIN:  s_next.amin  = wdata_i;
							brtr_pkg::OFF_AHOUR: s_next.ahour = wdata_i;
							brtr_pkg::OFF_AMON:  s_next.amon  = wdata_i;
							default:             s_next.adate = wdata_i;
						endcase
					end
				end
				brtr_pkg::OFF_CLR:   s_next.flags = s_reg.flags & ~wdata_i[2:0];
				brtr_pkg::OFF_INTCR: s_next.int_cr = wdata_i;
				brtr_pkg::OFF_INTSL: s_next.int_sel = wdata_i;
				default: s_next.hold = s_reg.hold;
			endcase
		end
		// Counting stops entirely under a time hold; a calendar hold stops the calendar.
		if (tick && !s_reg.hold[brtr_pkg::HOLD_TIME]) begin
			s_next.flags[brtr_pkg::ST_SEC] = 1'b1;
			s_next.sec = cnt_nx[0];
			if (wrap[0]) s_next.min = cnt_nx[1];
			if (&wrap[1:0]) s_next.hour = cnt_nx[2];
			// A day carry during a calendar hold is dropped; keep such holds short.
			if (&wrap[2:0] && !s_reg.hold[brtr_pkg::HOLD_CAL]) begin
				s_next.wday = wday_nx;
				s_next.date = cnt_nx[3];
				if (wrap[3]) s_next.mon = cnt_nx[4];
				if (&wrap[4:3]) s_next.year = cnt_nx[5];
				if (&wrap[5:3]) s_next.cent = cnt_nx[6];
			end
		end
		if (tick && al_hit) begin
			s_next.flags[brtr_pkg::ST_ALARM] = 1'b1;
		end
		if ((|s_reg.hold) && !s_reg.hold_d) begin
			s_next.flags[brtr_pkg::ST_ACK] = 1'b1;
		end
	end

	// ==========================================================
	// State register.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_reg       <= '0;
			s_reg.sec   <= brtr_pkg::RST_TIME;
			s_reg.min   <= brtr_pkg::RST_TIME;
			s_reg.hour  <= brtr_pkg::RST_TIME;
			s_reg.wday  <= brtr_pkg::RST_WDAY;
			s_reg.date  <= brtr_pkg::RST_DATE;
			s_reg.mon   <= brtr_pkg::RST_MON;
			s_reg.year  <= brtr_pkg::RST_YEAR;
			s_reg.cent  <= brtr_pkg::RST_CENT;
			s_reg.adate <= brtr_pkg::RST_DATE;
			s_reg.amon  <= brtr_pkg::RST_MON;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence bad_time_wr;
		wr_dat && s_reg.idx == brtr_pkg::OFF_SEC && s_reg.hold[brtr_pkg::HOLD_TIME] && !chk_ok;
	endsequence
	sequence rejected;
		s_reg.tval[brtr_pkg::VAL_TIME] && $stable(s_reg.sec);
	endsequence

	a_reset_load: assert property ($rose(resetn_i) |-> s_reg.year == brtr_pkg::RST_YEAR
		&& s_reg.cent == brtr_pkg::RST_CENT && s_reg.wday == brtr_pkg::RST_WDAY)
		else $error("reset calendar wrong");
	a_reset_alarm: assert property ($rose(resetn_i) |-> s_reg.adate == brtr_pkg::RST_DATE
		&& s_reg.amon == brtr_pkg::RST_MON && s_reg.asec == brtr_pkg::RST_TIME)
		else $error("reset alarm wrong");
	a_time_hold: assert property (s_reg.hold[brtr_pkg::HOLD_TIME] && !wr_dat
		|=> $stable(s_reg.sec) && $stable(s_reg.hour))
		else $error("time moved under hold");
	a_cal_frozen: assert property (s_reg.hold[brtr_pkg::HOLD_TIME] && !wr_dat
		|=> $stable(s_reg.date) && $stable(s_reg.wday))
		else $error("calendar moved under time hold");
	a_cal_time_runs: assert property (s_reg.hold == 2'b10 && tick
		|=> s_reg.sec != $past(s_reg.sec))
		else $error("time stopped by calendar hold");
	a_sec_range: assert property (s_reg.sec <= brtr_pkg::MAX_MS && s_reg.sec[3:0] <= 4'h9)
		else $error("seconds out of range");
	a_hour_range: assert property (s_reg.hour <= brtr_pkg::MAX_HOUR)
		else $error("hours out of range");
	a_wday_range: assert property (s_reg.wday >= brtr_pkg::BCD_ONE
		&& s_reg.wday <= brtr_pkg::MAX_WDAY)
		else $error("weekday out of range");
	a_cent_range: assert property (s_reg.cent == brtr_pkg::MIN_CENT
		|| s_reg.cent == brtr_pkg::MAX_CENT)
		else $error("century out of range");
	a_bad_entry: assert property (bad_time_wr |=> rejected)
		else $error("bad entry loaded");
	a_index_kept: assert property ((rd_en_i || wr_dat) && !wr_idx |=> $stable(s_reg.idx))
		else $error("index changed by data access");
	a_unmapped_zero: assert property (rd_en_i && bus_sel_i && !rd_hit |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");

endmodule

`default_nettype wire

// *** common/brtr_pkg.sv ***
`default_nettype none

package brtr_pkg;

	// ==========================================================
	// Internal offsets
	localparam logic [7:0] OFF_CR    = 8'h00;
	localparam logic [7:0] OFF_SEC   = 8'h04;
	localparam logic [7:0] OFF_MIN   = 8'h05;
	localparam logic [7:0] OFF_HOUR  = 8'h06;
	localparam logic [7:0] OFF_WDAY  = 8'h08;
	localparam logic [7:0] OFF_DATE  = 8'h09;
	localparam logic [7:0] OFF_MON   = 8'h0a;
	localparam logic [7:0] OFF_YEAR  = 8'h0b;
	localparam logic [7:0] OFF_CENT  = 8'h0c;
	localparam logic [7:0] OFF_ASEC  = 8'h10;
	localparam logic [7:0] OFF_AMIN  = 8'h11;
	localparam logic [7:0] OFF_AHOUR = 8'h12;
	localparam logic [7:0] OFF_AMON  = 8'h13;
	localparam logic [7:0] OFF_ADATE = 8'h14;
	localparam logic [7:0] OFF_SR    = 8'h18;
	localparam logic [7:0] OFF_CLR   = 8'h1c;
	localparam logic [7:0] OFF_INTCR = 8'h20;
	localparam logic [7:0] OFF_INTSL = 8'h24;
	localparam logic [7:0] OFF_TVAL  = 8'h28;
	localparam logic [7:0] OFF_AVAL  = 8'h29;

	// ==========================================================
	// Field positions
	localparam int HOLD_TIME = 0;
	localparam int HOLD_CAL  = 1;
	localparam int ST_ACK    = 0;
	localparam int ST_ALARM  = 1;
	localparam int ST_SEC    = 2;
	localparam int VAL_TIME  = 0;
	localparam int VAL_CAL   = 1;
	localparam int AL_EN     = 7;

	// ==========================================================
	// Reset values and BCD limits
	localparam logic [7:0] RST_TIME = 8'h00;
	localparam logic [7:0] RST_WDAY = 8'h04;
	localparam logic [7:0] RST_DATE = 8'h01;
	localparam logic [7:0] RST_MON  = 8'h01;
	localparam logic [7:0] RST_YEAR = 8'h98;
	localparam logic [7:0] RST_CENT = 8'h19;
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE  = 8'h01;
	localparam logic [7:0] MAX_MS   = 8'h59;
	localparam logic [7:0] MAX_HOUR = 8'h23;
	localparam logic [7:0] MAX_WDAY = 8'h07;
	localparam logic [7:0] MAX_DATE = 8'h31;
	localparam logic [7:0] MAX_MON  = 8'h12;
	localparam logic [7:0] MAX_YEAR = 8'h99;
	localparam logic [7:0] MIN_CENT = 8'h19;
	localparam logic [7:0] MAX_CENT = 8'h20;
	localparam logic [7:0] LEN_28   = 8'h28;
	localparam logic [7:0] LEN_29   = 8'h29;
	localparam logic [7:0] LEN_30   = 8'h30;
	localparam logic [7:0] MON_FEB  = 8'h02;
	localparam logic [7:0] MON_APR  = 8'h04;
	localparam logic [7:0] MON_JUN  = 8'h06;
	localparam logic [7:0] MON_SEP  = 8'h09;
	localparam logic [7:0] MON_NOV  = 8'h11;
	localparam logic [3:0] DIGIT_MAX = 4'h9;

	// ==========================================================
	// Timing
	localparam int SEC_NS   = 1000000000;
	localparam int CLK_NS   = 10;
	localparam int TICK_CYC = SEC_NS / CLK_NS;
	localparam int DIV_W    = 27;

	// ==========================================================
	// Block state
	typedef struct packed {
		logic [7:0]       idx;
		logic [1:0]       hold;
		logic             hold_d;
		logic [7:0]       sec;
		logic [7:0]       min;
		logic [7:0]       hour;
		logic [7:0]       wday;
		logic [7:0]       date;
		logic [7:0]       mon;
		logic [7:0]       year;
		logic [7:0]       cent;
		logic [7:0]       asec;
		logic [7:0]       amin;
		logic [7:0]       ahour;
		logic [7:0]       amon;
		logic [7:0]       adate;
		logic [2:0]       flags;
		logic [7:0]       int_cr;
		logic [7:0]       int_sel;
		logic [1:0]       tval;
		logic             aval;
		logic [7:0]       rdata;
		logic [DIV_W-1:0] div;
	} brtr_state_t;

endpackage

`default_nettype wire

// *** hw/brtr_bcd_check.sv ***
`default_nettype none

module brtr_bcd_check (
	// Value and limits
	input  wire logic [7:0] val_i,
	input  wire logic [7:0] lo_i,
	input  wire logic [7:0] hi_i,
	// Verdict
	output logic            ok_o
);

	// ==========================================================
	// Both digits must be decimal before a range compare is meaningful.
	always_comb begin
		ok_o = (val_i[3:0] <= brtr_pkg::DIGIT_MAX) && (val_i[7:4] <= brtr_pkg::DIGIT_MAX)
			&& (val_i >= lo_i) && (val_i <= hi_i);
	end

endmodule

`default_nettype wire

// *** hw/brtr_bcd_step.sv ***
`default_nettype none

module brtr_bcd_step (
	// Counter and limits
	input  wire logic [7:0] val_i,
	input  wire logic [7:0] lo_i,
	input  wire logic [7:0] hi_i,
	// Next value
	output logic [7:0]      nxt_o,
	output logic            wrap_o
);

	// ==========================================================
	// A value at or past the top wraps, so a stray code heals itself.
	always_comb begin
		wrap_o = (val_i >= hi_i);
		if (wrap_o) begin
			nxt_o = lo_i;
		end else if (val_i[3:0] >= brtr_pkg::DIGIT_MAX) begin
			nxt_o = {val_i[7:4] + 4'h1, 4'h0};
		end else begin
			nxt_o = {val_i[7:4], val_i[3:0] + 4'h1};
		end
	end

endmodule

`default_nettype wire

// *** tb/brtr_host_model.sv ***
`default_nettype none

module brtr_host_model (
	// Clock
	input  wire logic       clk_i,
	// Bus towards the block
	output logic            bus_sel_o,
	output logic            wr_en_o,
	output logic            rd_en_o,
	output logic [7:0]      wdata_o,
	input  wire logic [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		bus_sel_o = 1'b0;
		wr_en_o   = 1'b0;
		rd_en_o   = 1'b0;
		wdata_o   = 8'h00;
	end

	// ==========================================================
	// Bus cycles
	// One strobe per access, held over exactly one rising edge.
	// Released data is inverted so a stale value never looks valid.
	task automatic access(input logic sel, input logic wr, input logic [7:0] d);
		@(negedge clk_i);
		bus_sel_o = sel;
		wr_en_o   = wr;
		rd_en_o   = !wr;
		wdata_o   = d;
		@(negedge clk_i);
		wr_en_o   = 1'b0;
		rd_en_o   = 1'b0;
		wdata_o   = ~d;
	endtask

	task automatic read_raw(input logic sel, output logic [7:0] d);
		access(sel, 1'b0, 8'h00);
		@(negedge clk_i);
		d = rdata_i;
	endtask

	task automatic write_reg(input logic [7:0] off, input logic [7:0] d);
		access(1'b0, 1'b1, off);
		access(1'b1, 1'b1, d);
	endtask

	task automatic read_reg(input logic [7:0] off, output logic [7:0] d);
		access(1'b0, 1'b1, off);
		read_raw(1'b1, d);
	endtask

	// ==========================================================
	// Update handshake
	// Counters are written only after the acknowledge reads one.
	task automatic request_hold(input logic [1:0] bits, output logic ok);
		logic [7:0] st;
		// A stale acknowledge from an earlier update must not let this one pass.
		write_reg(brtr_pkg::OFF_CLR, 8'h01);
		write_reg(brtr_pkg::OFF_CR, {6'h00, bits});
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			read_reg(brtr_pkg::OFF_SR, st);
			ok = (st[brtr_pkg::ST_ACK] === 1'b1);
		end
	endtask

endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none

`define CHK(got, exp) \
	begin checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// A short tick keeps day rollover reachable in a few hundred cycles.
	localparam int TICK = 200;

	logic       clk_i;
	logic       resetn_i;
	logic       bus_sel;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] d;
	logic [7:0] s0;
	logic       ok;
	int         n_fail;
	int         checks;

	brtr_core #(.TICK_CYCLES(TICK)) u_dut (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.bus_sel_i(bus_sel),
		.wr_en_i  (wr_en),
		.rd_en_i  (rd_en),
		.wdata_i  (wdata),
		.rdata_o  (rdata)
	);

	brtr_host_model u_host (
		.clk_i    (clk_i),
		.bus_sel_o(bus_sel),
		.wr_en_o  (wr_en),
		.rd_en_o  (rd_en),
		.wdata_o  (wdata),
		.rdata_i  (rdata)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ==========================================================
	// Verdict
	task automatic give_verdict();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	// Seconds come first: they move on the first tick after reset, together with the seconds flag in status.
	task automatic test_reset_values();
		logic [7:0] off [20] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b,
			8'h0c, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h00, 8'h18, 8'h20, 8'h24,
			8'h28, 8'h29, 8'h01};
		logic [7:0] val [20] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h01, 8'h98,
			8'h19, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 20; i++) begin
			u_host.read_reg(off[i], d);
			`CHK(d, val[i])
		end
	endtask

	task automatic test_index_kept();
		u_host.write_reg(8'h0b, 8'h00);
		u_host.read_raw(1'b1, d);
		u_host.read_raw(1'b1, d);
		`CHK(d, 8'h98)
		u_host.read_raw(1'b0, d);
		`CHK(d, 8'h0b)
		u_host.write_reg(8'h10, 8'hda);
		u_host.read_reg(8'h29, d);
		`CHK(d, 8'h01)
		u_host.write_reg(8'h10, 8'h85);
		u_host.read_reg(8'h10, d);
		`CHK(d, 8'h85)
		u_host.read_reg(8'h29, d);
		`CHK(d, 8'h00)
	endtask

	task automatic test_time_hold();
		u_host.request_hold(2'b01, ok);
		`CHK(ok, 1'b1)
		u_host.write_reg(8'h04, 8'h5a);
		u_host.read_reg(8'h28, d);
		`CHK(d[0], 1'b1)
		u_host.write_reg(8'h04, 8'h59);
		u_host.write_reg(8'h05, 8'h60);
		u_host.write_reg(8'h05, 8'h59);
		u_host.write_reg(8'h06, 8'h24);
		u_host.read_reg(8'h06, d);
		`CHK(d, 8'h00)
		u_host.write_reg(8'h06, 8'ha3);
		u_host.write_reg(8'h06, 8'h23);
		u_host.read_reg(8'h28, d);
		`CHK(d[0], 1'b0)
		repeat (3 * TICK) @(negedge clk_i);
		u_host.read_reg(8'h04, d);
		`CHK(d, 8'h59)
		u_host.read_reg(8'h05, d);
		`CHK(d, 8'h59)
		u_host.read_reg(8'h06, d);
		`CHK(d, 8'h23)
		u_host.read_reg(8'h09, d);
		`CHK(d, 8'h01)
		u_host.write_reg(8'h00, 8'h00);
		repeat (TICK + 50) @(negedge clk_i);
		u_host.read_reg(8'h06, d);
		`CHK(d, 8'h00)
		u_host.read_reg(8'h09, d);
		`CHK(d, 8'h02)
		u_host.read_reg(8'h08, d);
		`CHK(d, 8'h05)
	endtask

	// Time must keep running while the calendar is reprogrammed.
	task automatic test_calendar_hold();
		logic [7:0] off [12] = '{8'h08, 8'h08, 8'h09, 8'h09, 8'h0a, 8'h0a, 8'h0a,
			8'h0b, 8'h0b, 8'h0c, 8'h0c, 8'h03};
		logic [7:0] wv [12] = '{8'h00, 8'h07, 8'h32, 8'h31, 8'h13, 8'h00, 8'h02,
			8'h9a, 8'h99, 8'h21, 8'h20, 8'h55};
		logic [7:0] ev [12] = '{8'h05, 8'h07, 8'h02, 8'h31, 8'h01, 8'h01, 8'h01,
			8'h98, 8'h99, 8'h19, 8'h20, 8'h00};
		u_host.request_hold(2'b10, ok);
		`CHK(ok, 1'b1)
		u_host.read_reg(8'h04, s0);
		repeat (2 * TICK) @(negedge clk_i);
		u_host.read_reg(8'h04, d);
		`CHK(d !== s0, 1'b1)
		for (int i = 0; i < 12; i++) begin
			u_host.write_reg(off[i], wv[i]);
			u_host.read_reg(off[i], d);
			`CHK(d, ev[i])
		end
		u_host.write_reg(8'h28, 8'hff);
		u_host.read_reg(8'h28, d);
		`CHK(d, 8'h00)
		u_host.write_reg(8'h00, 8'h00);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		n_fail   = 0;
		checks   = 0;
		resetn_i = 1'b0;
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		resetn_i = 1'b1;
		test_reset_values();
		test_index_kept();
		test_time_hold();
		test_calendar_hold();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		give_verdict();
	end

endmodule

`default_nettype wire
